// ### boot_seq_pkg.sv
// constants and types for the scan-driven boot sequencer
package boot_seq_pkg;

  localparam int unsigned CLOCK_MHZ      = 200;
  localparam int unsigned SETUP_WAIT_US  = 230;
  localparam int unsigned SETUP_WAIT_CYC = SETUP_WAIT_US * CLOCK_MHZ;
  localparam int unsigned WAIT_W         = 16;
  localparam int unsigned RELOAD_NS      = 500;
  localparam int unsigned RELOAD_CYC     = (RELOAD_NS * CLOCK_MHZ + 999) / 1000;
  localparam int unsigned PULSE_W        = 8;
  localparam int unsigned CHAIN_W        = 8;

  typedef enum logic [1:0] {
    SCHEME_SERIAL_HOST   = 2'h0,
    SCHEME_BYTE_HOST     = 2'h1,
    SCHEME_SERIAL_ROM    = 2'h2,
    SCHEME_PARALLEL_ROM  = 2'h3
  } scheme_e;

  typedef enum logic [3:0] {
    ST_POWER_UP = 4'h1,
    ST_LOADING  = 4'h2,
    ST_USER     = 4'h4,
    ST_PARKED   = 4'h8
  } boot_state_e;

  localparam logic [CHAIN_W-1:0] CHAIN_RESET = 8'h00;

endpackage : boot_seq_pkg

// ### pulse_stretch.sv
// fixed-length pulse generator for the internal reload request
`timescale 1ns/1ps
module pulse_stretch
  import boot_seq_pkg::*;
(
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic start,
  output logic      busy
);
  logic [PULSE_W-1:0] count_reg;
  logic [PULSE_W-1:0] count_next;

  assign count_next = start ? PULSE_W'(RELOAD_CYC)
                    : (count_reg != '0) ? count_reg - PULSE_W'(1) : count_reg;

  always_ff @(posedge clock) begin
    if (reset) begin
      count_reg <= '0;
      busy      <= 1'b0;
    end else begin
      count_reg <= count_next;
      busy      <= (count_next != '0);
    end
  end
endmodule : pulse_stretch

// ### scan_boot_seq.sv
// sequencer for scan-port configuration instructions and self-boot parking
`timescale 1ns/1ps
module scan_boot_seq
  import boot_seq_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                reset,
  input  wire boot_seq_pkg::scheme_e schemeSelectPins,
  input  wire logic                reloadRequestNPin,
  input  wire logic                pinSetupInstr,
  input  wire logic                reloadTriggerInstr,
  input  wire logic                resumeInstr,
  input  wire logic                parkInstr,
  input  wire logic                tapResetEntry,
  input  wire logic                scanProgramUserMode,
  input  wire logic                bootDone,
  input  wire logic [CHAIN_W-1:0]  chainDefault,
  output logic                     loadStateNPin,
  output logic                     userIoHighZ,
  output logic [CHAIN_W-1:0]       pinSetupShiftChain,
  output logic                     controllerParked,
  output logic                     reconfigStart,
  output logic                     reloadPinDisabled,
  output logic                     pinSetupReady,
  output logic                     userMode
);
  import boot_seq_pkg::*;

  boot_state_e        state_reg;
  boot_state_e        state_next;
  logic               parked_reg;
  logic               reloadDis_reg;
  logic [WAIT_W-1:0]  wait_reg;
  logic               reloadPrev_reg;
  logic               pulseBusy;

  wire selfBoot   = (schemeSelectPins == SCHEME_SERIAL_ROM) ||
                    (schemeSelectPins == SCHEME_PARALLEL_ROM);
  wire serialRom  = (schemeSelectPins == SCHEME_SERIAL_ROM);
  wire reloadPin  = reloadDis_reg ? 1'b1 : reloadRequestNPin;
  wire reloadRise = reloadPin && !reloadPrev_reg;
  // park ignored in host-fed schemes
  wire parkHit    = parkInstr && selfBoot;
  // resume restarts loading in every scheme, acting as trigger when host-fed
  wire reconfig   = reloadTriggerInstr || resumeInstr || !reloadPin;
  wire reEngage   = parked_reg && (scanProgramUserMode || resumeInstr ||
                    (serialRom && tapResetEntry));
  wire waitStart  = reloadRise || reloadTriggerInstr || resumeInstr;
  wire setupTake  = pinSetupInstr && (state_reg != ST_POWER_UP) && reloadPin;

  pulse_stretch u_reload (
    .clock (clock),
    .reset (reset),
    .start (reconfig && !pulseBusy),
    .busy  (pulseBusy)
  );

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_POWER_UP: begin
        if (parkHit) state_next = ST_PARKED;
        else if (reloadPin && wait_reg == '0) state_next = ST_LOADING;
      end
      ST_LOADING: begin
        if (parkHit) state_next = ST_PARKED;
        else if (bootDone && !pulseBusy) state_next = ST_USER;
      end
      ST_USER: begin
        if (reconfig) state_next = ST_LOADING;
        else if (parkHit) state_next = ST_PARKED;
      end
      ST_PARKED: begin
        if (scanProgramUserMode) state_next = ST_USER;
        else if (reEngage) state_next = ST_LOADING;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg          <= ST_POWER_UP;
      parked_reg         <= 1'b0;
      reloadDis_reg      <= 1'b0;
      wait_reg           <= WAIT_W'(SETUP_WAIT_CYC);
      reloadPrev_reg     <= 1'b1;
      loadStateNPin      <= 1'b0;
      userIoHighZ        <= 1'b1;
      pinSetupShiftChain <= CHAIN_RESET;
      controllerParked   <= 1'b0;
      reconfigStart      <= 1'b0;
      reloadPinDisabled  <= 1'b0;
      pinSetupReady      <= 1'b0;
      userMode           <= 1'b0;
    end else begin
      state_reg      <= state_next;
      reloadPrev_reg <= reloadPin;
      if (parkHit) parked_reg <= 1'b1;
      else if (reEngage) parked_reg <= 1'b0;
      if (resumeInstr && !selfBoot) reloadDis_reg <= 1'b1;
      if (waitStart) wait_reg <= WAIT_W'(SETUP_WAIT_CYC);
      else if (wait_reg != '0) wait_reg <= wait_reg - WAIT_W'(1);
      if (setupTake) pinSetupShiftChain <= chainDefault;
      // status pin follows loading only, never the pin-setup instruction
      loadStateNPin     <= reloadPin && !pulseBusy;
      userIoHighZ       <= setupTake || (state_next != ST_USER);
      controllerParked  <= parkHit || (parked_reg && !reEngage);
      reconfigStart     <= reconfig && !pulseBusy;
      reloadPinDisabled <= reloadDis_reg || (resumeInstr && !selfBoot);
      // a restarted wait must drop ready at once, not one cycle late
      pinSetupReady     <= (state_next != ST_POWER_UP) && reloadPin && !waitStart &&
                           (wait_reg == '0);
      userMode          <= (state_next == ST_USER);
    end
  end

  a_park_ignored: assert property (@(posedge clock) disable iff (reset)
    parkInstr && !selfBoot && !parked_reg |=> !parked_reg)
    else $error("park changed state in host-fed scheme");
  a_park_sets: assert property (@(posedge clock) disable iff (reset)
    parkInstr && selfBoot |=> controllerParked)
    else $error("park did not idle controller");
  a_io_highz: assert property (@(posedge clock) disable iff (reset)
    setupTake |=> userIoHighZ)
    else $error("user io driven during pin setup");
  a_resume_reload: assert property (@(posedge clock) disable iff (reset)
    resumeInstr && !pulseBusy |=> reconfigStart ##1 pulseBusy)
    else $error("resume did not start reconfiguration");
  a_parallel_pin: assert property (@(posedge clock) disable iff (reset)
    parked_reg && !serialRom && !resumeInstr && !scanProgramUserMode |=> parked_reg)
    else $error("parallel controller re-engaged without resume");
  a_user_engage: assert property (@(posedge clock) disable iff (reset)
    parked_reg && scanProgramUserMode |=> !parked_reg && state_reg == ST_USER)
    else $error("controller not re-engaged in user mode");
  a_tap_engage: assert property (@(posedge clock) disable iff (reset)
    parked_reg && serialRom && tapResetEntry |=> !parked_reg)
    else $error("serial controller not re-engaged on tap reset");
  a_status_free: assert property (@(posedge clock) disable iff (reset)
    setupTake && reloadPin && !pulseBusy && !reconfig |=> loadStateNPin)
    else $error("pin setup drove load state low");
  a_pin_disable: assert property (@(posedge clock) disable iff (reset)
    resumeInstr && !selfBoot |=> reloadPinDisabled [*2])
    else $error("reload pin not disabled after resume");

  // length of the internal reload pulse, for the check below
  logic [PULSE_W-1:0] busyLen_reg;

  always_ff @(posedge clock) begin
    if (reset) busyLen_reg <= '0;
    else if (pulseBusy) busyLen_reg <= busyLen_reg + PULSE_W'(1);
    else busyLen_reg <= '0;
  end

  a_pulse_len: assert property (@(posedge clock) disable iff (reset)
    $fell(pulseBusy) |-> busyLen_reg == PULSE_W'(RELOAD_CYC))
    else $error("internal reload pulse has wrong length");

  a_chain_load: assert property (@(posedge clock) disable iff (reset)
    setupTake |=> pinSetupShiftChain == $past(chainDefault))
    else $error("pin setup chain not reloaded");

  a_chain_hold: assert property (@(posedge clock) disable iff (reset)
    !setupTake |=> $stable(pinSetupShiftChain))
    else $error("pin setup chain changed without instruction");

  a_highz_load: assert property (@(posedge clock) disable iff (reset)
    !userMode |-> userIoHighZ)
    else $error("user io driven outside user mode");

  a_ready_wait: assert property (@(posedge clock) disable iff (reset)
    waitStart |=> !pinSetupReady)
    else $error("pin setup ready during restart wait");

  a_ready_powerup: assert property (@(posedge clock) disable iff (reset)
    pinSetupReady |-> state_reg != ST_POWER_UP)
    else $error("pin setup ready in power-up state");

  a_ready_reload: assert property (@(posedge clock) disable iff (reset)
    !reloadPin |=> !pinSetupReady)
    else $error("pin setup ready while reload pin low");

  a_reconfig_once: assert property (@(posedge clock) disable iff (reset)
    reconfigStart |=> !reconfigStart)
    else $error("reconfig start longer than one cycle");

  a_status_low: assert property (@(posedge clock) disable iff (reset)
    reconfig && !pulseBusy |=> ##1 !loadStateNPin)
    else $error("load state not low during reload");

  a_trigger_start: assert property (@(posedge clock) disable iff (reset)
    reloadTriggerInstr && !pulseBusy |=> reconfigStart)
    else $error("trigger did not start reconfiguration");

  a_host_resume: assert property (@(posedge clock) disable iff (reset)
    resumeInstr && !selfBoot && !pulseBusy |=> reconfigStart)
    else $error("host-fed resume did not act as trigger");

  a_disable_sticky: assert property (@(posedge clock) disable iff (reset)
    reloadPinDisabled |=> reloadPinDisabled)
    else $error("reload pin disable not sticky");

  a_parked_out: assert property (@(posedge clock) disable iff (reset)
    controllerParked == parked_reg)
    else $error("parked output differs from parked flag");

  a_user_leave: assert property (@(posedge clock) disable iff (reset)
    state_reg == ST_USER && reconfig |=> state_reg == ST_LOADING)
    else $error("user mode not left on reconfiguration");

  a_parked_hold: assert property (@(posedge clock) disable iff (reset)
    state_reg == ST_PARKED && !reEngage && !scanProgramUserMode |=> state_reg == ST_PARKED)
    else $error("parked controller left idle on its own");

  a_powerup_park: assert property (@(posedge clock) disable iff (reset)
    state_reg == ST_POWER_UP && parkHit |=> state_reg == ST_PARKED)
    else $error("park ignored in power-up state");

  a_state_onehot: assert property (@(posedge clock) disable iff (reset)
    $onehot(state_reg))
    else $error("sequencer state not one-hot");
endmodule : scan_boot_seq

// ### scan_host_model.sv
// host-side model of the scan cable issuing configuration instructions
`timescale 1ns/1ps
module scan_host_model
  import boot_seq_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  pinSetupReady,
  output logic [5:0] instr,
  output logic       reloadRequestNPin
);
  initial begin
    instr = 6'h00;
    reloadRequestNPin = 1'b1;
  end
  // one-cycle instruction pulse
  task automatic issue(input int k);
    @(negedge clock) instr[k] = 1'b1;
    @(negedge clock) instr[k] = 1'b0;
  endtask : issue
  // reload pin held low past the minimum
  task automatic reload();
    @(negedge clock) reloadRequestNPin = 1'b0;
    repeat (RELOAD_CYC + 1) @(negedge clock);
    reloadRequestNPin = 1'b1;
  endtask : reload
  // pin setup only once the wait has run out
  task automatic setup(output bit ok);
    for (int i = 0; i < 50000 && !(pinSetupReady === 1'b1 && reloadRequestNPin); i++) begin
      @(negedge clock);
    end
    ok = (pinSetupReady === 1'b1);
    if (ok) issue(0);
  endtask : setup
endmodule : scan_host_model

// ### tb_top.sv
// self-checking bench for the scan boot sequencer
`timescale 1ns/1ps
module tb_top;
  import boot_seq_pkg::*;
  logic               clock, reset, reloadN, bootDone, ready, seenRec, seenHz, ok, prevLoad;
  logic [5:0]         instr;
  logic [CHAIN_W-1:0] chainDefault, chain;
  scheme_e            scheme;
  logic               loadN, highZ, parked, recStart, disabled, userMode;
  int                 n_mismatch, n_checks, expParked, expDisabled;
  // tens digit scheme, units digit event
  int                 plan[$] = '{33, 34, 36, 32, 33, 35, 23, 21, 24, 3, 2, 13, 16};
  scan_boot_seq scan_boot_seq_inst (.clock(clock), .reset(reset), .schemeSelectPins(scheme),
    .reloadRequestNPin(reloadN), .pinSetupInstr(instr[0]), .reloadTriggerInstr(instr[1]),
    .resumeInstr(instr[2]), .parkInstr(instr[3]), .tapResetEntry(instr[4]),
    .scanProgramUserMode(instr[5]), .bootDone(bootDone), .chainDefault(chainDefault),
    .loadStateNPin(loadN), .userIoHighZ(highZ), .pinSetupShiftChain(chain),
    .controllerParked(parked), .reconfigStart(recStart), .reloadPinDisabled(disabled),
    .pinSetupReady(ready), .userMode(userMode));
  scan_host_model scan_host_model_inst (.clock(clock), .pinSetupReady(ready), .instr(instr),
    .reloadRequestNPin(reloadN));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(negedge clock) begin
    if (recStart === 1'b1) seenRec <= 1'b1;
    if (highZ === 1'b1) seenHz <= 1'b1;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // one host event, then the model predicts and compares
  task automatic ev(input int k);
    bit exRec;
    seenRec = 1'b0;
    if (k == 6) scan_host_model_inst.reload();
    else scan_host_model_inst.issue(k);
    repeat (120) @(negedge clock);
    exRec = (k == 1 || k == 2 || (k == 6 && expDisabled == 0));
    if (k == 3 && scheme >= SCHEME_SERIAL_ROM) expParked = 1;
    if ((k == 4 && scheme == SCHEME_SERIAL_ROM) || k == 2 || k == 5) expParked = 0;
    if (k == 2 && scheme < SCHEME_SERIAL_ROM) expDisabled = 1;
    check("parked", 8'(parked), 8'(expParked));
    check("reconfig", 8'(seenRec), 8'(exRec));
    check("reload off", 8'(disabled), 8'(expDisabled));
    if (k == 5) check("user mode", 8'(userMode), 8'h01);
    if (exRec) check("ready", 8'(ready), 8'h00);
    $display("event %0d scheme %0d done", k, scheme);
  endtask : ev
  initial begin
    void'($urandom(32'h3806FA6F));
    reset = 1'b1;
    bootDone = 1'b1;
    scheme = SCHEME_SERIAL_ROM;
    chainDefault = CHAIN_W'($urandom);
    seenRec = 1'b0;
    seenHz = 1'b0;
    repeat (2) @(negedge clock);
    check("load state", 8'(loadN), 8'h00);
    check("high z", 8'(highZ), 8'h01);
    check("chain", 8'(chain), 8'(CHAIN_RESET));
    check("parked", 8'(parked), 8'h00);
    check("ready", 8'(ready), 8'h00);
    check("user mode", 8'(userMode), 8'h00);
    reset = 1'b0;
    scan_host_model_inst.setup(ok);
    if (!ok) n_mismatch++;
    prevLoad = loadN;
    repeat (4) @(negedge clock);
    check("chain", 8'(chain), 8'(chainDefault));
    check("tri-state", 8'(seenHz), 8'h01);
    check("load state", 8'(loadN), 8'(prevLoad));
    $display("pin setup test done");
    foreach (plan[i]) begin
      scheme = scheme_e'(plan[i] / 10);
      ev(plan[i] % 10);
    end
    wrap_up();
  end
endmodule : tb_top
